// ### shared/pwp_guard_map.svh
// Register offsets, reset values and bit positions of the peripheral write guard.
// Assumes byte addressing on the register port, one 32-bit word per register.
`ifndef PWP_GUARD_MAP_SVH
`define PWP_GUARD_MAP_SVH

// Register byte offsets
`define PWP_OFS_CLR 8'h00
`define PWP_OFS_SET 8'h04
`define PWP_OFS_STAT 8'h08
`define PWP_OFS_MASK 8'h0C

// Reset values
`define PWP_PROT_RST 32'h0000_0000
`define PWP_STAT_RST 3'h0
`define PWP_MASK_RST 3'h0

// Guard bits with a peripheral behind them on the third bridge (bits 1 to 19)
`define PWP_BRIDGE2_MASK 32'h000F_FFFE

// Status and mask bit positions
`define PWP_EV_BLOCKED 0
`define PWP_EV_DBL_SET 1
`define PWP_EV_DBL_CLR 2
`define PWP_EV_COUNT 3

`endif

// ### shared/pwp_pkg.sv
// Types shared by the peripheral write guard and its surroundings.
// Assumes the map header is compiled alongside.
package pwp_pkg;
   // One register word
   typedef logic [31:0] pwp_word_t;
   // Byte address on the register port
   typedef logic [7:0] pwp_addr_t;
   // Index of a guarded peripheral on the bridge
   typedef logic [4:0] pwp_index_t;
   // Bridge instance served by one guard
   typedef enum logic [1:0] {
      PWP_BRIDGE0 = 2'b00,
      PWP_BRIDGE1 = 2'b01,
      PWP_BRIDGE2 = 2'b10
   } pwp_bridge_t;
endpackage

// ### logic/pwp_guard.sv
// Peripheral write guard for one peripheral bus bridge: protection bits, write blocking,
// redundant protect/unprotect detection, event status with interrupt.
// Assumes one clock mclk from the bridge side; power manager and bridge are on that clock.
`timescale 1ns/100ps
`include "pwp_guard_map.svh"

module pwp_guard #(
   parameter pwp_pkg::pwp_bridge_t INSTANCE = pwp_pkg::PWP_BRIDGE2,
   parameter logic [31:0] PRESENT_MASK = `PWP_BRIDGE2_MASK
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Power manager clock gate requests
   input wire logic pm_clk_on,
   input wire logic pm_clk_off,
   output logic guard_bus_clock,
   // Register port
   input wire pwp_pkg::pwp_addr_t reg_addr,
   input wire pwp_pkg::pwp_word_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_debug,
   output pwp_pkg::pwp_word_t reg_rdata,
   output logic reg_err,
   // Peripheral write check from the bridge
   input wire logic pw_req,
   input wire pwp_pkg::pwp_index_t pw_index,
   input wire logic pw_debug,
   output logic pw_grant,
   output logic pw_error,
   // Protection state and interrupt
   output pwp_pkg::pwp_word_t protect_vec,
   output logic irq
);
   import pwp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   generate
      if (INSTANCE == PWP_BRIDGE2 && PRESENT_MASK != `PWP_BRIDGE2_MASK) begin : g_bad_map
         $error("Third bridge guard needs the fixed peripheral map");
      end
      if (PRESENT_MASK[0] !== 1'b0 && INSTANCE == PWP_BRIDGE2) begin : g_bad_bit0
         $error("Bit zero has no peripheral on the third bridge");
      end
   endgenerate

   // Clock of the third bridge starts gated off, the others on
   localparam logic CLK_RESET = (INSTANCE == PWP_BRIDGE2) ? 1'b0 : 1'b1;

   // Address match, used for every register
   function automatic logic addr_is(input pwp_addr_t addr, input pwp_addr_t ofs);
      addr_is = (addr == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State

   logic clk_on_ff; // Guard bus clock gate
   logic nxt_clk_on;
   pwp_word_t prot_ff; // Protection bits
   pwp_word_t nxt_prot;
   logic [`PWP_EV_COUNT-1:0] stat_ff; // Sticky event flags
   logic [`PWP_EV_COUNT-1:0] nxt_stat;
   logic [`PWP_EV_COUNT-1:0] mask_ff; // Interrupt mask
   logic [`PWP_EV_COUNT-1:0] nxt_mask;
   pwp_word_t rdata_ff; // Read data, one cycle after the strobe
   pwp_word_t nxt_rdata;
   logic err_ff; // Register write error answer
   logic nxt_err;
   logic grant_ff; // Peripheral write allowed
   logic nxt_grant;
   logic perr_ff; // Peripheral write refused
   logic nxt_perr;
   logic irq_ff; // Interrupt level
   logic nxt_irq;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock gate: the register logic only moves while the gate is on, just as a
   // gated bus clock would freeze it. Sleep states do not enter here at all.

   assign nxt_clk_on = pm_clk_on ? 1'b1 : (pm_clk_off ? 1'b0 : clk_on_ff);

   // Gated strobes
   wire live = clk_on_ff;
   wire wr_g = reg_wr & live;
   wire rd_g = reg_rd & live;

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode

   wire hit_clr = addr_is(reg_addr, `PWP_OFS_CLR);
   wire hit_set = addr_is(reg_addr, `PWP_OFS_SET);
   wire hit_stat = addr_is(reg_addr, `PWP_OFS_STAT);
   wire hit_mask = addr_is(reg_addr, `PWP_OFS_MASK);
   wire hit_any = hit_clr | hit_set | hit_stat | hit_mask;

   // Bits that name an attached peripheral; empty positions are dropped here
   wire pwp_word_t wbits = reg_wdata & PRESENT_MASK;
   wire wr_clr = wr_g & hit_clr;
   wire wr_set = wr_g & hit_set;

   // Redundant requests; the debugger is never faulted for them
   wire dbl_set = wr_set & ~reg_debug & |(wbits & prot_ff);
   wire dbl_clr = wr_clr & ~reg_debug & |(wbits & ~prot_ff);

   ////////////////////////////////////////////////////////////////////////////////
   // Protection bits: a one clears or sets, a zero leaves the bit alone

   assign nxt_prot = wr_set ? (prot_ff | wbits) :
                     wr_clr ? (prot_ff & ~wbits) : prot_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Peripheral write check. Software that protects from several contexts should
   // read the set address first; the guard itself keeps no owner.

   wire pw_live = pw_req & live;
   wire pw_prot = prot_ff[pw_index] & PRESENT_MASK[pw_index];
   wire pw_block = pw_live & pw_prot & ~pw_debug;

   assign nxt_grant = pw_live & ~pw_block;
   assign nxt_perr = pw_block;

   ////////////////////////////////////////////////////////////////////////////////
   // Register answers

   // Both protection addresses show the same vector
   wire pwp_word_t rd_sel = (hit_clr | hit_set) ? prot_ff :
                            hit_stat ? {29'h0, stat_ff} :
                            hit_mask ? {29'h0, mask_ff} : 32'h0000_0000;

   assign nxt_rdata = rd_g ? rd_sel : 32'h0000_0000;
   // Unmapped writes are refused too, so a stray pointer does not pass silently
   assign nxt_err = dbl_set | dbl_clr | (wr_g & ~hit_any);

   ////////////////////////////////////////////////////////////////////////////////
   // Events and interrupt: a new event beats a write-one-to-clear in the same cycle

   wire [`PWP_EV_COUNT-1:0] ev_set;
   assign ev_set[`PWP_EV_BLOCKED] = pw_block;
   assign ev_set[`PWP_EV_DBL_SET] = dbl_set;
   assign ev_set[`PWP_EV_DBL_CLR] = dbl_clr;

   wire [`PWP_EV_COUNT-1:0] ev_clr = (wr_g & hit_stat) ? reg_wdata[`PWP_EV_COUNT-1:0] : '0;

   assign nxt_stat = ev_set | (stat_ff & ~ev_clr);
   assign nxt_mask = (wr_g & hit_mask) ? reg_wdata[`PWP_EV_COUNT-1:0] : mask_ff;
   assign nxt_irq = |(nxt_stat & mask_ff);

   ////////////////////////////////////////////////////////////////////////////////
   // Flip-flops

   // Gate and protection state
   always_ff @(posedge mclk) begin
      if (reset) begin
         clk_on_ff <= CLK_RESET;
         prot_ff <= `PWP_PROT_RST;
      end else begin
         clk_on_ff <= nxt_clk_on;
         prot_ff <= nxt_prot;
      end
   end

   // Status and mask
   always_ff @(posedge mclk) begin
      if (reset) begin
         stat_ff <= `PWP_STAT_RST;
         mask_ff <= `PWP_MASK_RST;
         irq_ff <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
         irq_ff <= nxt_irq;
      end
   end

   // Bus answers
   always_ff @(posedge mclk) begin
      if (reset) begin
         rdata_ff <= 32'h0000_0000;
         err_ff <= 1'b0;
         grant_ff <= 1'b0;
         perr_ff <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         err_ff <= nxt_err;
         grant_ff <= nxt_grant;
         perr_ff <= nxt_perr;
      end
   end

   // Outputs straight from flip-flops
   assign guard_bus_clock = clk_on_ff;
   assign protect_vec = prot_ff;
   assign reg_rdata = rdata_ff;
   assign reg_err = err_ff;
   assign pw_grant = grant_ff;
   assign pw_error = perr_ff;
   assign irq = irq_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   chk_blocked_write: assert property (
      @(posedge mclk) disable iff (reset)
      (pw_req && clk_on_ff && !pw_debug && prot_ff[pw_index] && PRESENT_MASK[pw_index])
      |=> (pw_error && !pw_grant && stat_ff[`PWP_EV_BLOCKED]))
      else $error("Write to protected peripheral was not refused");

   chk_debug_bypass: assert property (
      @(posedge mclk) disable iff (reset)
      (pw_req && clk_on_ff && pw_debug) |=> (pw_grant && !pw_error))
      else $error("Debugger write was not let through");

   chk_set_bits: assert property (
      @(posedge mclk) disable iff (reset)
      (reg_wr && clk_on_ff && reg_addr == `PWP_OFS_SET)
      |=> ((protect_vec & (($past(reg_wdata)) & PRESENT_MASK)) == ($past(reg_wdata) & PRESENT_MASK)))
      else $error("Set write did not set protection");

   chk_clear_bits: assert property (
      @(posedge mclk) disable iff (reset)
      (reg_wr && clk_on_ff && reg_addr == `PWP_OFS_CLR)
      |=> ((protect_vec & $past(reg_wdata)) == 32'h0000_0000))
      else $error("Clear write did not clear protection");

   chk_double_set: assert property (
      @(posedge mclk) disable iff (reset)
      (reg_wr && clk_on_ff && !reg_debug && reg_addr == `PWP_OFS_SET && |(reg_wdata & prot_ff & PRESENT_MASK))
      |=> (reg_err && stat_ff[`PWP_EV_DBL_SET]))
      else $error("Double protect not flagged");

   chk_double_clear: assert property (
      @(posedge mclk) disable iff (reset)
      (reg_wr && clk_on_ff && !reg_debug && reg_addr == `PWP_OFS_CLR
       && |(reg_wdata & ~prot_ff & PRESENT_MASK))
      |=> (reg_err && stat_ff[`PWP_EV_DBL_CLR]))
      else $error("Double unprotect not flagged");

   chk_same_view: assert property (
      @(posedge mclk) disable iff (reset)
      (reg_rd && clk_on_ff && (reg_addr == `PWP_OFS_CLR || reg_addr == `PWP_OFS_SET))
      |=> (reg_rdata == $past(prot_ff)))
      else $error("Protection views disagree");

   chk_zero_write: assert property (
      @(posedge mclk) disable iff (reset)
      (reg_wr && (reg_addr == `PWP_OFS_SET || reg_addr == `PWP_OFS_CLR) && reg_wdata == 32'h0000_0000)
      |=> ($stable(protect_vec) && !reg_err))
      else $error("Zero write changed protection or faulted");

   chk_empty_bits: assert property (
      @(posedge mclk) disable iff (reset)
      (protect_vec & ~PRESENT_MASK) == 32'h0000_0000)
      else $error("Empty guard position holds a one");

   chk_gate_freeze: assert property (
      @(posedge mclk) disable iff (reset)
      (!clk_on_ff && !pm_clk_on) [*2] |-> ($stable(protect_vec) && !pw_grant && !pw_error))
      else $error("Guard moved while its clock was gated");

endmodule // pwp_guard

// ### verification/pwp_bus_model.sv
// Bridge-side model: processor and debugger as bus masters, and the power manager gate requests.
// Assumes the guard samples every request on the rising edge of mclk.
`timescale 1ns/100ps
module pwp_bus_model (
   // Clock
   input wire logic mclk,
   // Power manager requests
   output logic pm_clk_on,
   output logic pm_clk_off,
   // Register port
   output pwp_pkg::pwp_addr_t reg_addr,
   output pwp_pkg::pwp_word_t reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic reg_debug,
   input wire pwp_pkg::pwp_word_t reg_rdata,
   input wire logic reg_err,
   // Peripheral write check
   output logic pw_req,
   output pwp_pkg::pwp_index_t pw_index,
   output logic pw_debug,
   input wire logic pw_grant,
   input wire logic pw_error
);
   import pwp_pkg::*;
   // Idle bus at time zero
   initial begin
      {pm_clk_on, pm_clk_off, reg_wr, reg_rd, reg_debug, pw_req, pw_debug} = 7'h00;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      pw_index = 5'h00;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One register access; the answer stands only in the cycle after the strobe
   task automatic reg_op(input logic wr, input pwp_addr_t a, input pwp_word_t d, input logic dbg,
                         output pwp_word_t rd, output logic err);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_debug <= dbg;
      if (wr) begin
         reg_wr <= 1'b1;
      end else begin
         reg_rd <= 1'b1;
      end
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      // Released lines show the inverse, so a stale value never looks live
      reg_addr <= ~a;
      reg_wdata <= ~d;
      #1;
      rd = reg_rdata;
      err = reg_err;
   endtask
   // One peripheral write request from the bridge
   task automatic pw_op(input pwp_index_t i, input logic dbg, output logic g, output logic e);
      @(posedge mclk);
      pw_req <= 1'b1;
      pw_index <= i;
      pw_debug <= dbg;
      @(posedge mclk);
      pw_req <= 1'b0;
      pw_index <= ~i;
      #1;
      g = pw_grant;
      e = pw_error;
   endtask
   // One-cycle gate request from the power manager
   task automatic gate(input logic on);
      @(posedge mclk);
      pm_clk_on <= on;
      pm_clk_off <= ~on;
      @(posedge mclk);
      pm_clk_on <= 1'b0;
      pm_clk_off <= 1'b0;
      #1;
   endtask
endmodule // pwp_bus_model

// ### verification/tb_top.sv
// Self-checking bench for the peripheral write guard on the third bridge.
// Assumes the bus model drives every guard input except mclk and reset, which the bench drives; offsets, reset and map expectations come from the map header.
`timescale 1ns/100ps
`include "pwp_guard_map.svh"
module tb_top;
   import pwp_pkg::*;
   // Clock, reset and bookkeeping
   logic mclk = 1'b0;
   logic reset = 1'b1;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;
   pwp_word_t rd;
   logic err, g, e;
   // Guard ports
   logic pm_clk_on, pm_clk_off, guard_bus_clock, reg_wr, reg_rd, reg_debug, reg_err;
   logic pw_req, pw_debug, pw_grant, pw_error, irq;
   pwp_addr_t reg_addr;
   pwp_word_t reg_wdata, reg_rdata, protect_vec;
   pwp_index_t pw_index;
   always #4 mclk = ~mclk;
   pwp_guard uut (.mclk(mclk), .reset(reset), .pm_clk_on(pm_clk_on), .pm_clk_off(pm_clk_off),
      .guard_bus_clock(guard_bus_clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_debug(reg_debug), .reg_rdata(reg_rdata), .reg_err(reg_err), .pw_req(pw_req),
      .pw_index(pw_index), .pw_debug(pw_debug), .pw_grant(pw_grant), .pw_error(pw_error),
      .protect_vec(protect_vec), .irq(irq));
   pwp_bus_model bus (.mclk(mclk), .pm_clk_on(pm_clk_on), .pm_clk_off(pm_clk_off), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_debug(reg_debug), .reg_rdata(reg_rdata),
      .reg_err(reg_err), .pw_req(pw_req), .pw_index(pw_index), .pw_debug(pw_debug), .pw_grant(pw_grant),
      .pw_error(pw_error));
   ////////////////////////////////////////////////////////////////////////////////
   // Single comparison point; four-state compare so an unknown never matches
   task automatic check(input string what, input pwp_word_t seen, input pwp_word_t exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 1000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Gate is off after reset and swallows writes until turned on
   task automatic t_gate_on();
      check("gate", 32'(guard_bus_clock), 32'h0000_0000);
      bus.reg_op(1'b1, `PWP_OFS_SET, 32'hFFFF_FFFF, 1'b0, rd, err);
      check("vec", protect_vec, `PWP_PROT_RST);
      check("gated err", 32'(err), 32'h0000_0000);
      bus.gate(1'b1);
      check("gate", 32'(guard_bus_clock), 32'h0000_0001);
      $display("Test gate_on done");
   endtask
   // Set all, empty positions ignored, both views read the same vector
   task automatic t_set_views();
      bus.reg_op(1'b1, `PWP_OFS_SET, 32'hFFFF_FFFF, 1'b0, rd, err);
      check("err", 32'(err), 32'h0000_0000);
      check("vec", protect_vec, `PWP_BRIDGE2_MASK);
      bus.reg_op(1'b0, `PWP_OFS_CLR, 32'h0000_0000, 1'b0, rd, err);
      check("clr view", rd, `PWP_BRIDGE2_MASK);
      bus.reg_op(1'b0, `PWP_OFS_SET, 32'h0000_0000, 1'b0, rd, err);
      check("set view", rd, `PWP_BRIDGE2_MASK);
      $display("Test set_views done");
   endtask
   // Blocked writes, debugger bypass, double protect
   task automatic t_block();
      bus.pw_op(5'h03, 1'b0, g, e);
      check("pw", 32'({g, e}), 32'h0000_0001);
      bus.pw_op(5'h03, 1'b1, g, e);
      check("pw dbg", 32'({g, e}), 32'h0000_0002);
      bus.pw_op(5'h00, 1'b0, g, e);
      check("pw empty", 32'({g, e}), 32'h0000_0002);
      bus.reg_op(1'b1, `PWP_OFS_SET, 32'h0000_0008, 1'b0, rd, err);
      check("dbl set", 32'(err), 32'h0000_0001);
      bus.reg_op(1'b1, `PWP_OFS_SET, 32'h0000_0008, 1'b1, rd, err);
      check("dbg set", 32'(err), 32'h0000_0000);
      $display("Test block done");
   endtask
   // Unprotect after reading state, zero writes, double unprotect
   task automatic t_clear();
      bus.reg_op(1'b0, `PWP_OFS_SET, 32'h0000_0000, 1'b0, rd, err);
      bus.reg_op(1'b1, `PWP_OFS_CLR, rd & 32'h0000_0008, 1'b0, rd, err);
      check("vec", protect_vec, 32'h000F_FFF6);
      bus.reg_op(1'b1, `PWP_OFS_CLR, 32'h0000_0000, 1'b0, rd, err);
      bus.reg_op(1'b1, `PWP_OFS_SET, 32'h0000_0000, 1'b0, rd, err);
      check("zero err", 32'(err), 32'h0000_0000);
      check("vec", protect_vec, 32'h000F_FFF6);
      bus.reg_op(1'b1, `PWP_OFS_CLR, 32'h0000_0008, 1'b0, rd, err);
      check("dbl clr", 32'(err), 32'h0000_0001);
      bus.pw_op(5'h03, 1'b0, g, e);
      check("pw", 32'({g, e}), 32'h0000_0002);
      $display("Test clear done");
   endtask
   // Status, mask, interrupt, unmapped address
   task automatic t_irq();
      bus.reg_op(1'b0, `PWP_OFS_STAT, 32'h0000_0000, 1'b0, rd, err);
      check("status", rd, 32'h0000_0007);
      check("irq masked", 32'(irq), 32'h0000_0000);
      bus.reg_op(1'b1, `PWP_OFS_MASK, 32'h0000_0001, 1'b0, rd, err);
      @(posedge mclk);
      #1;
      check("irq", 32'(irq), 32'h0000_0001);
      bus.reg_op(1'b1, `PWP_OFS_STAT, 32'h0000_0001, 1'b0, rd, err);
      @(posedge mclk);
      #1;
      check("irq cleared", 32'(irq), 32'h0000_0000);
      bus.reg_op(1'b1, 8'h10, 32'h0000_0001, 1'b0, rd, err);
      check("unmapped err", 32'(err), 32'h0000_0001);
      bus.reg_op(1'b0, 8'h10, 32'h0000_0000, 1'b0, rd, err);
      check("unmapped rd", rd, 32'h0000_0000);
      $display("Test irq done");
   endtask
   // Reset in mid-run: gate, protection, status, mask and interrupt all return to reset values
   task automatic t_reset();
      bus.reg_op(1'b1, `PWP_OFS_MASK, 32'h0000_0007, 1'b0, rd, err);
      bus.reg_op(1'b0, `PWP_OFS_MASK, 32'h0000_0000, 1'b0, rd, err);
      check("mask", rd, 32'h0000_0007);
      check("irq on", 32'(irq), 32'h0000_0001);
      @(posedge mclk);
      reset <= 1'b1;
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      #1;
      check("rst gate", 32'(guard_bus_clock), 32'h0000_0000);
      check("rst vec", protect_vec, `PWP_PROT_RST);
      check("rst irq", 32'(irq), 32'h0000_0000);
      bus.gate(1'b1);
      bus.reg_op(1'b0, `PWP_OFS_STAT, 32'h0000_0000, 1'b0, rd, err);
      check("rst status", rd, 32'h0000_0000);
      bus.reg_op(1'b0, `PWP_OFS_MASK, 32'h0000_0000, 1'b0, rd, err);
      check("rst mask", rd, 32'h0000_0000);
      $display("Test reset done");
   endtask
   // Gate off: peripheral checks get no answer at all
   task automatic t_gate_off();
      bus.gate(1'b0);
      check("gate", 32'(guard_bus_clock), 32'h0000_0000);
      bus.pw_op(5'h04, 1'b0, g, e);
      check("pw off", 32'({g, e}), 32'h0000_0000);
      $display("Test gate_off done");
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      // Let the releasing edge settle before the first look at the outputs
      #1;
      t_gate_on();
      t_set_views();
      t_block();
      t_clear();
      t_irq();
      t_reset();
      t_gate_off();
      tally_and_finish();
   end
endmodule // tb_top
